// >>> cfg_regs_pkg.sv
// Operation
// - Link format register resets to 0xb5, pixel rate range 10.
// - Serial rate range field resets to 11.
// - Parity enable resets 0; parallel width code resets 101 (18 bits).
// - Spread register resets 0x1f: spread 000, reserved ones.
// - Start timeout divider resets 1010, pixel clock over 1024.
// - Start timeout count resets 0000, counts to one tick.
// - End timeout register resets 0xa0: divider 1010, count 0000.
// - Control register reset is 0x28 when remote select low, else 0x30.
// - Vsync edge falling, pixel clock edge rising by default.
// - Filter PLL bypass and PRBS test enable reset to 0.
// - End frame code resets 0xff.
// - Peripheral interface register resets to zero: UART, disabled, slow rate.
// - Come-back timeout resets 000, base mode rate code 00.
// - PRBS length 0000; upper GPIO inputs with zero values.
// - Lower GPIO directions reset to inputs, values reset to 0x00.
// - Preemphasis register resets 0xe0, level 111, reserved zeros.
// - Glitch filter width resets 00; widths 100, 50, 10 ns.
// - Control-unit activity restarts start and end timeout timers.
package cfg_regs_pkg;
    localparam logic [3:0] OFS_LINK_FORMAT = 4'h0;
    localparam logic [3:0] OFS_SPREAD = 4'h1;
    localparam logic [3:0] OFS_START_TO = 4'h2;
    localparam logic [3:0] OFS_END_TO = 4'h3;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_OWN_ADDR = 4'h5;
    localparam logic [3:0] OFS_END_FRAME = 4'h6;
    localparam logic [3:0] OFS_PARTNER_ADDR = 4'h7;
    localparam logic [3:0] OFS_PERIPH = 4'h8;
    localparam logic [3:0] OFS_PRBS_GPIO = 4'h9;
    localparam logic [3:0] OFS_GPIO_DIR = 4'ha;
    localparam logic [3:0] OFS_GPIO_VAL = 4'hb;
    localparam logic [3:0] OFS_PREEMPH = 4'hc;
    localparam logic [3:0] OFS_GLITCH = 4'hd;
    localparam logic [3:0] OFS_LOCK = 4'he;
    localparam int NUM_REGS = 15;

    localparam logic [7:0] RST_LINK_FORMAT = 8'hb5;
    localparam logic [7:0] RST_SPREAD = 8'h1f;
    localparam logic [7:0] RST_START_TO = 8'ha0;
    localparam logic [7:0] RST_END_TO = 8'ha0;
    localparam logic [7:0] RST_CONTROL_LOCAL = 8'h28;
    localparam logic [7:0] RST_CONTROL_REMOTE = 8'h30;
    localparam logic [7:0] RST_OWN_ADDR = 8'hfa;
    localparam logic [7:0] RST_END_FRAME = 8'hff;
    localparam logic [7:0] RST_PARTNER_ADDR = 8'hf8;
    localparam logic [7:0] RST_PERIPH = 8'h00;
    localparam logic [7:0] RST_PRBS_GPIO = 8'h00;
    localparam logic [7:0] RST_GPIO_DIR = 8'h00;
    localparam logic [7:0] RST_GPIO_VAL = 8'h00;
    localparam logic [7:0] RST_PREEMPH = 8'he0;
    localparam logic [7:0] RST_GLITCH = 8'h00;
    localparam logic [7:0] RST_LOCK = 8'h00;

    // Writable bit masks; cleared bits are reserved or read only
    localparam logic [7:0] WMASK_SPREAD = 8'he0;
    localparam logic [7:0] WMASK_CONTROL = 8'hbd;
    localparam logic [7:0] WMASK_PREEMPH = 8'he0;
    localparam logic [7:0] WMASK_GLITCH = 8'h03;
    localparam logic [7:0] WMASK_LOCK = 8'h00;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam int LOCK_BIT = 0;

    // Timeout divider: tick every 2**code pixel clocks
    localparam logic [3:0] TO_DIV_RESET_CODE = 4'ha;
    localparam int TO_DIV_W = 16;
    localparam int TO_CNT_W = 5;

    // Glitch filter widths in ns at the 20 MHz clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int GF_SLOW_NS = 100;
    localparam int GF_MID_NS = 50;
    localparam int GF_FAST_NS = 10;
    localparam int GF_SLOW_CYC = (GF_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GF_MID_CYC = (GF_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GF_FAST_CYC = (GF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] pixel_rate_range;
        logic [1:0] serial_rate_range;
        logic parity_enable;
        logic [2:0] parallel_width_code;
    } link_format_t;

    typedef struct packed {
        logic vsync_edge_select;
        logic rsvd6;
        logic pixel_clock_edge_select;
        logic power_down;
        logic serializer_enable;
        logic filter_pll_bypass;
        logic rsvd1;
        logic prbs_test_enable;
    } control_t;

    typedef struct packed {
        logic peripheral_protocol_select;
        logic peripheral_interface_enable;
        logic fast_uart;
        logic [2:0] comeback_timeout;
        logic [1:0] base_mode_rate_code;
    } periph_t;

    typedef struct packed {
        logic [3:0] prbs_length_code;
        logic upper_pin9_direction;
        logic upper_pin8_direction;
        logic upper_pin9_value;
        logic upper_pin8_value;
    } prbs_gpio_t;

    typedef struct packed {
        logic [3:0] divider;
        logic [3:0] count;
    } timeout_cfg_t;
endpackage

// >>> timeout_timer.sv
`timescale 1ns/1ps
module timeout_timer
    import cfg_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic restart,
    input cfg_regs_pkg::timeout_cfg_t cfg,
    output logic expired
);
    import cfg_regs_pkg::*;
    logic [TO_DIV_W-1:0] div_q;
    logic [TO_CNT_W-1:0] cnt_q;
    logic exp_q;
    wire logic [TO_DIV_W-1:0] div_top = TO_DIV_W'((32'd1 << cfg.divider) - 32'd1);
    wire logic tick = run && (div_q == div_top);
    wire logic [TO_CNT_W-1:0] cnt_top = {1'b0, cfg.count} + TO_CNT_W'(1);

    // Restart outranks expiry so late activity keeps the channel open
    always_ff @(posedge clk) begin
        if (rst || restart || !run) begin
            div_q <= '0;
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else if (tick && !exp_q) begin
            div_q <= '0;
            cnt_q <= cnt_q + TO_CNT_W'(1);
            exp_q <= (cnt_q + TO_CNT_W'(1)) >= cnt_top;
        end else if (!exp_q) begin
            div_q <= div_q + TO_DIV_W'(1);
        end
    end
    assign expired = exp_q;
endmodule

// >>> serializer_config_registers.sv
`timescale 1ns/1ps
module serializer_config_registers
    import cfg_regs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic REMOTE_SELECT_PIN,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RDATA_VALID,
    input wire logic LOCKED,
    input wire logic CHANNEL_OPEN,
    input wire logic CU_ACTIVITY,
    output cfg_regs_pkg::link_format_t LINK_FORMAT,
    output logic [2:0] SPREAD_CODE,
    output cfg_regs_pkg::control_t CONTROL,
    output logic [7:0] OWN_ADDR,
    output logic [7:0] PARTNER_ADDR,
    output logic [7:0] END_FRAME,
    output cfg_regs_pkg::periph_t PERIPH,
    output cfg_regs_pkg::prbs_gpio_t PRBS_GPIO,
    output logic [7:0] GPIO_DIR,
    output logic [7:0] GPIO_VAL,
    output logic [2:0] PREEMPHASIS_LEVEL,
    output logic [1:0] GLITCH_FILTER_WIDTH,
    output logic [1:0] GLITCH_FILTER_CYCLES,
    output logic START_TIMEOUT_EXPIRED,
    output logic END_TIMEOUT_EXPIRED
);
    import cfg_regs_pkg::*;

    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic rst_seen_q;

    // Reset values; the control register follows the remote select strap
    function automatic logic [7:0] reset_value(input int idx, input logic remote);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            0: v = RST_LINK_FORMAT;
            1: v = RST_SPREAD;
            2: v = RST_START_TO;
            3: v = RST_END_TO;
            4: v = remote ? RST_CONTROL_REMOTE : RST_CONTROL_LOCAL;
            5: v = RST_OWN_ADDR;
            6: v = RST_END_FRAME;
            7: v = RST_PARTNER_ADDR;
            8: v = RST_PERIPH;
            9: v = RST_PRBS_GPIO;
            10: v = RST_GPIO_DIR;
            11: v = RST_GPIO_VAL;
            12: v = RST_PREEMPH;
            13: v = RST_GLITCH;
            14: v = RST_LOCK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] write_mask(input int idx);
        logic [7:0] m;
        m = WMASK_FULL;
        case (idx)
            1: m = WMASK_SPREAD;
            4: m = WMASK_CONTROL;
            12: m = WMASK_PREEMPH;
            13: m = WMASK_GLITCH;
            14: m = WMASK_LOCK;
            default: m = WMASK_FULL;
        endcase
        return m;
    endfunction

    // Synchronous reset samples the strap each reset cycle, no async capture
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            localparam logic [7:0] WM = write_mask(g);
            wire logic hit = WR_EN && (ADDR == 4'(g));
            wire logic [7:0] rst_v = reset_value(g, REMOTE_SELECT_PIN);
            wire logic [7:0] merged = (WDATA & WM) | (regs_q[g] & ~WM);
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    regs_q[g] <= rst_v;
                end else if (hit) begin
                    regs_q[g] <= merged;
                end
            end
        end
    endgenerate

    // Lock bit mirrors hardware state, never software writes
    wire logic [7:0] lock_rd = {regs_q[OFS_LOCK][7:1], LOCKED};
    wire logic addr_ok = ADDR < 4'(NUM_REGS);
    wire logic [7:0] rd_sel = !addr_ok ? 8'h00 : (ADDR == OFS_LOCK) ? lock_rd : regs_q[ADDR];

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= RD_EN ? rd_sel : rdata_q;
            rvalid_q <= RD_EN;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        rst_seen_q <= RST;
    end

    assign RDATA = rdata_q;
    assign RDATA_VALID = rvalid_q && !rst_seen_q;

    // Field outputs
    assign LINK_FORMAT = link_format_t'(regs_q[OFS_LINK_FORMAT]);
    assign SPREAD_CODE = regs_q[OFS_SPREAD][7:5];
    assign CONTROL = control_t'(regs_q[OFS_CONTROL]);
    assign OWN_ADDR = regs_q[OFS_OWN_ADDR];
    assign END_FRAME = regs_q[OFS_END_FRAME];
    assign PARTNER_ADDR = regs_q[OFS_PARTNER_ADDR];
    assign PERIPH = periph_t'(regs_q[OFS_PERIPH]);
    assign PRBS_GPIO = prbs_gpio_t'(regs_q[OFS_PRBS_GPIO]);
    assign GPIO_DIR = regs_q[OFS_GPIO_DIR];
    assign GPIO_VAL = regs_q[OFS_GPIO_VAL];
    assign PREEMPHASIS_LEVEL = regs_q[OFS_PREEMPH][7:5];
    assign GLITCH_FILTER_WIDTH = regs_q[OFS_GLITCH][1:0];

    // Filter width in cycles follows the selected base mode rate
    wire logic [1:0] gf_slow = 2'(GF_SLOW_CYC);
    wire logic [1:0] gf_mid = 2'(GF_MID_CYC);
    wire logic [1:0] gf_fast = 2'(GF_FAST_CYC);
    assign GLITCH_FILTER_CYCLES = (PERIPH.base_mode_rate_code == 2'h0) ? gf_slow :
                                  (PERIPH.base_mode_rate_code == 2'h1) ? gf_mid : gf_fast;

    // Activity from the control unit or a register access restarts both timers
    wire logic activity = CU_ACTIVITY || WR_EN || RD_EN;

    timeout_timer u_start_to (
        .clk(SYS_CLK),
        .rst(RST),
        .run(CHANNEL_OPEN),
        .restart(activity),
        .cfg(timeout_cfg_t'(regs_q[OFS_START_TO])),
        .expired(START_TIMEOUT_EXPIRED)
    );

    timeout_timer u_end_to (
        .clk(SYS_CLK),
        .rst(RST),
        .run(CHANNEL_OPEN),
        .restart(activity),
        .cfg(timeout_cfg_t'(regs_q[OFS_END_TO])),
        .expired(END_TIMEOUT_EXPIRED)
    );
endmodule

// >>> cfg_regs_props.sv
`timescale 1ns/1ps
module cfg_regs_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic REMOTE_SELECT_PIN,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic LOCKED,
    input cfg_regs_pkg::link_format_t LINK_FORMAT,
    input cfg_regs_pkg::control_t CONTROL,
    input wire logic [7:0] OWN_ADDR,
    input wire logic [7:0] PARTNER_ADDR,
    input wire logic [7:0] END_FRAME,
    input cfg_regs_pkg::periph_t PERIPH,
    input wire logic [7:0] GPIO_DIR
);
    import cfg_regs_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_own_wr;
        WR_EN && ADDR == OFS_OWN_ADDR;
    endsequence
    sequence s_lock_rd;
        RD_EN && ADDR == OFS_LOCK;
    endsequence
    AST_LINK_RST: assert property ($fell(RST) |-> LINK_FORMAT == 8'hb5)
        else $error("link format reset value wrong");
    AST_CTRL_RST: assert property ($fell(RST) |->
        CONTROL == ($past(REMOTE_SELECT_PIN) ? 8'h30 : 8'h28))
        else $error("control reset value wrong");
    AST_ADDR_RST: assert property ($fell(RST) |->
        OWN_ADDR == 8'hfa && PARTNER_ADDR == 8'hf8 && END_FRAME == 8'hff)
        else $error("address reset values wrong");
    AST_GPIO_RST: assert property ($fell(RST) |->
        PERIPH == 8'h00 && GPIO_DIR == 8'h00)
        else $error("peripheral or gpio reset wrong");
    AST_OWN_WRITE: assert property (s_own_wr |=> OWN_ADDR == $past(WDATA))
        else $error("own address write lost");
    AST_LOCK_READ: assert property (s_lock_rd |=> RDATA == {7'h00, $past(LOCKED)})
        else $error("lock status read wrong");
    AST_UNMAPPED: assert property (RD_EN && ADDR == 4'hf |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_RSVD: assert property (WR_EN ##1 1'b1 |-> !CONTROL.rsvd6 && !CONTROL.rsvd1)
        else $error("control reserved bit set");
endmodule
bind serializer_config_registers cfg_regs_props u_props (.SYS_CLK(SYS_CLK), .RST(RST),
    .REMOTE_SELECT_PIN(REMOTE_SELECT_PIN), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .LOCKED(LOCKED), .LINK_FORMAT(LINK_FORMAT),
    .CONTROL(CONTROL), .OWN_ADDR(OWN_ADDR), .PARTNER_ADDR(PARTNER_ADDR),
    .END_FRAME(END_FRAME), .PERIPH(PERIPH), .GPIO_DIR(GPIO_DIR));

// >>> cfg_relay.sv
`timescale 1ns/1ps
module cfg_relay (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [3:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
    end
    // Released bus shows inverted values so stale data cannot pass
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= wr;
        rd_en <= !wr;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule

// >>> serializer_config_registers_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module serializer_config_registers_tb_top;
    import cfg_regs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pin = 1'b1, locked = 1'b0, chan = 1'b0, cu = 1'b0;
    logic wr_en, rd_en, rvalid, start_timeout, end_timeout;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, own, eb, part, ef, gdir, gval;
    logic [2:0] spread, pre;
    logic [1:0] gfw, gfc;
    link_format_t lf;
    control_t ctl;
    periph_t per;
    prbs_gpio_t prbs;
    logic [7:0] d [16];
    logic [7:0] rv [16] = '{8'hb5, 8'h1f, 8'ha0, 8'ha0, 8'h30, 8'hfa, 8'hff, 8'hf8,
        8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'h00, 8'h00};
    logic [7:0] wm [16] = '{8'hff, 8'he0, 8'hff, 8'hff, 8'hbd, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'he0, 8'h03, 8'h00, 8'h00};
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'hd6d5110e;
    int mismatches = 0, comparisons = 0;
    always #25 clk = ~clk;
    cfg_relay relay (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
    serializer_config_registers dut (.SYS_CLK(clk), .RST(rst), .REMOTE_SELECT_PIN(pin),
        .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
        .RDATA_VALID(rvalid), .LOCKED(locked), .CHANNEL_OPEN(chan), .CU_ACTIVITY(cu),
        .LINK_FORMAT(lf), .SPREAD_CODE(spread), .CONTROL(ctl), .OWN_ADDR(own),
        .PARTNER_ADDR(part), .END_FRAME(ef), .PERIPH(per), .PRBS_GPIO(prbs),
        .GPIO_DIR(gdir), .GPIO_VAL(gval), .PREEMPHASIS_LEVEL(pre),
        .GLITCH_FILTER_WIDTH(gfw), .GLITCH_FILTER_CYCLES(gfc),
        .START_TIMEOUT_EXPIRED(start_timeout), .END_TIMEOUT_EXPIRED(end_timeout));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic close_out;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic reset_dut(input logic p);
        rst <= 1'b1;
        pin <= p;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        relay.access(1'b0, a, 8'h00);
    endtask
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            eb = exp_q.pop_front();
            `CHK("rdata", eb, rdata)
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        reset_dut(1'b1);
        `CHK("pixel rate rst", 2'h2, lf.pixel_rate_range)
        `CHK("serial rate rst", 2'h3, lf.serial_rate_range)
        `CHK("width rst", 3'h5, lf.parallel_width_code)
        `CHK("spread rst", 3'h0, spread)
        `CHK("power down rst", 1'b1, ctl.power_down)
        `CHK("clock edge rst", 1'b1, ctl.pixel_clock_edge_select)
        `CHK("pll bypass rst", 1'b0, ctl.filter_pll_bypass)
        `CHK("prbs gpio rst", 8'h00, prbs)
        `CHK("gpio val rst", 8'h00, gval)
        `CHK("preemph rst", 3'h7, pre)
        `CHK("filter rst", 2'h0, gfw)
        `CHK("filter cyc rst", 2'h2, gfc)
        for (int i = 0; i < 16; i++) rd(i[3:0], rv[i]);
        reset_dut(1'b0);
        @(posedge clk);
        chan <= 1'b1;
        // Default timers: 1024 cycles at divider 1010, count 0000
        repeat (1000) @(posedge clk);
        `CHK("sto early", 1'b0, start_timeout)
        repeat (30) @(posedge clk);
        `CHK("sto", 1'b1, start_timeout)
        `CHK("eto", 1'b1, end_timeout)
        cu <= 1'b1;
        @(posedge clk);
        cu <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("sto restart", 1'b0, start_timeout | end_timeout)
        chan <= 1'b0;
        rd(OFS_CONTROL, 8'h28);
        locked <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            d[i] = seed[7:0];
            relay.access(1'b1, i[3:0], d[i]);
        end
        @(posedge clk);
        `CHK("own", d[5], own)
        `CHK("partner", d[7], part)
        `CHK("end frame", d[6], ef)
        `CHK("link", d[0], lf)
        `CHK("periph", d[8], per)
        `CHK("prbs gpio", d[9], prbs)
        `CHK("gpio dir", d[10], gdir)
        `CHK("gpio val", d[11], gval)
        `CHK("spread", d[1][7:5], spread)
        `CHK("preemph", d[12][7:5], pre)
        `CHK("filter", d[13][1:0], gfw)
        `CHK("control", (8'h28 & ~wm[4]) | (d[4] & wm[4]), ctl)
        for (int i = 0; i < 15; i++) rd(i[3:0], (rv[i] & ~wm[i]) | (d[i] & wm[i]) |
            ((i == 4) ? 8'h00 : 8'h00) | ((i == 14) ? 8'h01 : 8'h00));
        rd(4'hf, 8'h00);
        // 100 ns needs two 50 ns cycles; 50 ns and 10 ns need one
        for (int k = 0; k < 4; k++) begin
            relay.access(1'b1, OFS_PERIPH, {d[8][7:2], k[1:0]});
            @(posedge clk);
            `CHK("filter cyc", (k == 0) ? 2'h2 : 2'h1, gfc)
        end
        // Divider 2 count 1 expires after 8 cycles, divider 1 count 0 after 2
        relay.access(1'b1, OFS_START_TO, 8'h21);
        relay.access(1'b1, OFS_END_TO, 8'h10);
        chan <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("eto short early", 1'b0, end_timeout)
        @(posedge clk);
        `CHK("eto short", 1'b1, end_timeout)
        `CHK("sto short early", 1'b0, start_timeout)
        repeat (5) @(posedge clk);
        `CHK("sto short edge", 1'b0, start_timeout)
        @(posedge clk);
        `CHK("sto short", 1'b1, start_timeout)
        chan <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("reads left", 0, exp_q.size())
        close_out();
    end
endmodule
